/* bench/crof_rx_overflow_flags_tb.sv */
// Purpose: self-checking bench for the overflow flag block
// Assumes: apb slave answers in bounded time, store model on the far side
// Notes:   a fork lines a clearing write up with an overflow on the same edge
`timescale 1ns/1ps
`default_nettype none
module crof_rx_overflow_flags_tb;
   import crof_pkg::*;
   logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
   logic        pwrite = 1'h0, store_req = 1'h0, pready, pslverr, irq, err;
   logic [7:0]  paddr = 8'h00;
   logic [4:0]  store_idx = 5'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, store_attempt, buffer_full;
   int          n_fail = 0, comparisons = 0, i;
   logic [4:0]  r_idx [4] = '{5'h03, 5'h0f, 5'h10, 5'h1f};
   logic [7:0]  r_adr [4] = '{OFS_FLAGS_LOW, OFS_FLAGS_LOW, OFS_FLAGS_HIGH, OFS_FLAGS_HIGH};
   logic [31:0] r_exp [4] = '{32'h0008, 32'h8008, 32'h0001, 32'h8001};
   always #12.5 pclk = ~pclk;
   crof_rx_overflow_flags dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .store_attempt(store_attempt), .buffer_full(buffer_full), .irq(irq));
   crof_store_model model (.pclk(pclk), .presetn(presetn), .store_req(store_req),
      .store_idx(store_idx), .store_attempt(store_attempt), .buffer_full(buffer_full));
   task report_and_stop();
      if (n_fail == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel    <= 1'h1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      for (k = 0; pready !== 1'h1; k++)
      begin
         if (k == 20)
         begin
            n_fail++;
            report_and_stop();
         end
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask
   task store(input logic [4:0] b);
      store_req <= 1'h1;
      store_idx <= b;
      @(posedge pclk);
      store_req <= 1'h0;
      repeat (3) @(posedge pclk);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      apb(1'h0, OFS_FLAGS_HIGH, 32'h0);
      chk("flags high at reset", 32'h0, rd);
      store(5'h03);
      apb(1'h0, OFS_FLAGS_LOW, 32'h0);
      chk("flags after first store", 32'h0, rd);
      for (i = 0; i < 4; i++)
      begin
         store(r_idx[i]);
         store(r_idx[i]);
         apb(1'h0, r_adr[i], 32'h0);
         chk("flag word", r_exp[i], rd);
         chk("flag word error", 32'h0, {31'h0, err});
      end
      chk("irq while masked", 32'h0, {31'h0, irq});
      apb(1'h1, OFS_IRQ_MASK, 32'h3);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      apb(1'h1, OFS_IRQ_STATUS, 32'h3);
      chk("irq after clear", 32'h0, {31'h0, irq});
      apb(1'h1, OFS_FLAGS_LOW, 32'hffff);
      apb(1'h0, OFS_FLAGS_LOW, 32'h0);
      chk("flags after writing ones", 32'h8008, rd);
      apb(1'h1, OFS_FLAGS_LOW, 32'hfff7);
      apb(1'h0, OFS_FLAGS_LOW, 32'h0);
      chk("flags after one clear", 32'h8000, rd);
      fork
         store(5'h03);
         apb(1'h1, OFS_FLAGS_LOW, 32'h0);
      join
      chk("irq after overflow", 32'h1, {31'h0, irq});
      apb(1'h0, OFS_FLAGS_LOW, 32'h0);
      chk("flags after set and clear", 32'h0008, rd);
      apb(1'h1, OFS_FLAGS_HIGH, 32'h7fff);
      apb(1'h0, OFS_FLAGS_HIGH, 32'h0);
      chk("high flags after one clear", 32'h0001, rd);
      apb(1'h0, 8'h10, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped read data", 32'h0, rd);
      presetn <= 1'h0;
      @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      apb(1'h0, OFS_FLAGS_HIGH, 32'h0);
      chk("flags after second reset", 32'h0, rd);
      chk("irq after second reset", 32'h0, {31'h0, irq});
      report_and_stop();
   end
endmodule
`default_nettype wire

/* bench/crof_store_model.sv */
// Purpose: receive-side store logic that feeds the overflow flag block
// Assumes: buffers are never drained, so any second store overflows
// Notes:   a buffer turns full one cycle after its first store
`timescale 1ns/1ps
`default_nettype none
module crof_store_model
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        store_req,
   input  wire logic [4:0]  store_idx,
   output logic      [31:0] store_attempt,
   output logic      [31:0] buffer_full
);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         store_attempt <= 32'h0;
         buffer_full   <= 32'h0;
      end
      else
      begin
         store_attempt <= store_req ? (32'h1 << store_idx) : 32'h0;
         // full lags the store so the first store is never an overflow
         buffer_full   <= buffer_full | store_attempt;
      end
   end
endmodule
`default_nettype wire

/* hdl/crof_pkg.sv */
// Purpose: constants for the receive buffer overflow flag block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
package crof_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0]  OFS_FLAGS_LOW   = 8'h00;
   localparam logic [7:0]  OFS_FLAGS_HIGH  = 8'h04;
   localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h08;
   localparam logic [7:0]  OFS_IRQ_MASK    = 8'h0c;
   localparam int          ADDR_W          = 8;
   // ----------------------------------------
   // fields and reset values
   // ----------------------------------------
   localparam int          NUM_BUFFERS     = 32;
   localparam int          HALF_W          = 16;
   localparam int          HIGH_BASE       = 16;
   localparam int          IRQ_BIT_LOW     = 0;
   localparam int          IRQ_BIT_HIGH    = 1;
   localparam int          IRQ_W           = 2;
   localparam logic [15:0] FLAGS_RESET     = 16'h0000;
   localparam logic [1:0]  IRQ_RESET       = 2'h0;
endpackage

/* hdl/crof_rx_overflow_flags.sv */
// Purpose: sticky per-buffer receive overflow flags behind an apb slave
// Assumes: overflow strobes are synchronous to pclk, one bit per buffer
// Notes:   zero-wait apb slave; unmapped addresses read zero and flag pslverr
`timescale 1ns/1ps
`default_nettype none

// Contract
// - store attempt into a still-full buffer sets that buffer's overflow flag.
// - writing zero clears a flag; writing one leaves it unchanged.
// - low flag register holds buffers 0..15 at bit n.
// - high flag register holds buffers 16..31 at bit n minus 16.
// - zero means no overflow; all flags reset to zero.
module crof_rx_overflow_flags
#(
   parameter int N_BUF = crof_pkg::NUM_BUFFERS
)
(
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [crof_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic [N_BUF-1:0]            store_attempt,
   input  wire logic [N_BUF-1:0]            buffer_full,
   output logic                             irq
);
   import crof_pkg::*;

   // ----------------------------------------
   // elaboration check
   // ----------------------------------------
   // the map has exactly two 16-bit flag words
   if (N_BUF != NUM_BUFFERS)
   begin : g_bad_n
      $error("crof: N_BUF must equal 32");
   end

   // ----------------------------------------
   // decode
   // ----------------------------------------
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
      hit = (a == o);
   endfunction

   wire logic              access    = psel & penable;
   wire logic              wr        = access & pwrite;
   wire logic              sel_low   = hit(paddr, OFS_FLAGS_LOW);
   wire logic              sel_high  = hit(paddr, OFS_FLAGS_HIGH);
   wire logic              sel_stat  = hit(paddr, OFS_IRQ_STATUS);
   wire logic              sel_mask  = hit(paddr, OFS_IRQ_MASK);
   wire logic              mapped    = sel_low | sel_high | sel_stat | sel_mask;

   // ----------------------------------------
   // overflow flags
   // ----------------------------------------
   logic [N_BUF-1:0]       flags_r;
   logic [N_BUF-1:0]       flags_nxt;
   wire logic [N_BUF-1:0]  ovf_event = store_attempt & buffer_full;
   wire logic [N_BUF-1:0]  clr_vec;

   genvar gi;
   for (gi = 0; gi < N_BUF; gi++)
   begin : g_flag
      // low word maps bit n, high word maps bit n-16
      if (gi < HIGH_BASE)
      begin : g_lo
         assign clr_vec[gi] = wr & sel_low & ~pwdata[gi];
      end
      else
      begin : g_hi
         assign clr_vec[gi] = wr & sel_high & ~pwdata[gi-HIGH_BASE];
      end
   end

   // set after clear so a same-cycle overflow is never lost
   assign flags_nxt = (flags_r & ~clr_vec) | ovf_event;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flags_r <= {FLAGS_RESET, FLAGS_RESET};
      else
         flags_r <= flags_nxt;
   end

   // ----------------------------------------
   // interrupt status and mask
   // ----------------------------------------
   logic [IRQ_W-1:0]       stat_r;
   logic [IRQ_W-1:0]       stat_nxt;
   logic [IRQ_W-1:0]       mask_r;
   logic [IRQ_W-1:0]       mask_nxt;
   wire logic [IRQ_W-1:0]  irq_ev;
   wire logic [IRQ_W-1:0]  stat_clr = (wr & sel_stat) ? pwdata[IRQ_W-1:0] : IRQ_RESET;

   assign irq_ev[IRQ_BIT_LOW]  = |ovf_event[HIGH_BASE-1:0];
   assign irq_ev[IRQ_BIT_HIGH] = |ovf_event[N_BUF-1:HIGH_BASE];
   assign stat_nxt = (stat_r & ~stat_clr) | irq_ev;
   assign mask_nxt = (wr & sel_mask) ? pwdata[IRQ_W-1:0] : mask_r;
   wire logic irq_nxt = |(stat_nxt & mask_nxt);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stat_r <= IRQ_RESET;
         mask_r <= IRQ_RESET;
         irq    <= 1'b0;
      end
      else
      begin
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         irq    <= irq_nxt;
      end
   end

   // ----------------------------------------
   // apb read path
   // ----------------------------------------
   // read data registered in setup so it is stable through the access phase
   wire logic [31:0] rd_mux =
      sel_low  ? {16'h0000, flags_r[HALF_W-1:0]}
    : sel_high ? {16'h0000, flags_r[N_BUF-1:HIGH_BASE]}
    : sel_stat ? {30'h0, stat_r}
    : sel_mask ? {30'h0, mask_r}
    : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h00000000;
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
      end
   end

   // ----------------------------------------
   // checks: bus
   // ----------------------------------------
   sequence s_setup;
      psel && !penable;
   endsequence

   sequence s_read_setup;
      psel && !penable && !pwrite;
   endsequence

   sequence s_access;
      psel && penable;
   endsequence

   a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
      s_setup |=> pready)
      else $error("pready missing after setup");

   a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("pready held past the access cycle");

   a_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !psel |=> !pready)
      else $error("pready without a transfer");

   a_read_transfer: assert property (@(posedge pclk) disable iff (!presetn)
      (s_read_setup ##1 s_access) |-> pready)
      else $error("read access without pready");

   a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !mapped) |=> pslverr)
      else $error("unmapped address without pslverr");

   a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && mapped) |=> !pslverr)
      else $error("pslverr on a mapped address");

   a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("pslverr without pready");

   // read data is forced to zero outside a read so stale flags never leak
   a_rdata_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      !(psel && !penable && !pwrite) |=> prdata == 32'h00000000)
      else $error("read data outside a read access");

   a_low_readback: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && sel_low)
         |=> prdata == {16'h0000, $past(flags_r[15:0])})
      else $error("low flag word misread");

   a_high_readback: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && sel_high)
         |=> prdata == {16'h0000, $past(flags_r[31:16])})
      else $error("high flag word misread");

   a_stat_readback: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && sel_stat)
         |=> prdata == {30'h0, $past(stat_r)})
      else $error("status word misread");

   a_mask_readback: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && sel_mask)
         |=> prdata == {30'h0, $past(mask_r)})
      else $error("mask word misread");

   // ----------------------------------------
   // checks: flags
   // ----------------------------------------
   sequence s_ovf_any;
      (|ovf_event);
   endsequence

   sequence s_write_low;
      wr && sel_low;
   endsequence

   sequence s_write_high;
      wr && sel_high;
   endsequence

   a_reset_clears: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(presetn) |-> flags_r == {FLAGS_RESET, FLAGS_RESET} && !irq && !pready)
      else $error("state not cleared by reset");

   a_ovf_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
      s_ovf_any |=> (flags_r & $past(ovf_event)) == $past(ovf_event))
      else $error("overflow did not set its flag");

   a_one_write_keeps: assert property (@(posedge pclk) disable iff (!presetn)
      s_write_low |=> ($past(pwdata[15:0] & flags_r[15:0]) & ~flags_r[15:0]) == 16'h0000)
      else $error("writing one cleared a flag");

   a_zero_write_clears: assert property (@(posedge pclk) disable iff (!presetn)
      s_write_high |=> (flags_r[31:16] & ~$past(pwdata[15:0] | ovf_event[31:16])) == 16'h0000)
      else $error("writing zero did not clear a flag");

   a_low_spares_high: assert property (@(posedge pclk) disable iff (!presetn)
      s_write_low |=> ($past(flags_r[31:16]) & ~flags_r[31:16]) == 16'h0000)
      else $error("low word write touched a high flag");

   a_high_spares_low: assert property (@(posedge pclk) disable iff (!presetn)
      s_write_high |=> ($past(flags_r[15:0]) & ~flags_r[15:0]) == 16'h0000)
      else $error("high word write touched a low flag");

   a_no_spurious_set: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> (flags_r & ~$past(flags_r | ovf_event)) == '0)
      else $error("flag set without overflow");

   a_sticky_hold: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> ($past(flags_r & ~clr_vec) & ~flags_r) == '0)
      else $error("flag dropped without clear");

   a_set_beats_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (|(clr_vec & ovf_event))
         |=> (flags_r & $past(clr_vec & ovf_event)) == $past(clr_vec & ovf_event))
      else $error("clear beat a same-cycle overflow");

   // ----------------------------------------
   // checks: interrupt
   // ----------------------------------------
   a_stat_set_low: assert property (@(posedge pclk) disable iff (!presetn)
      (|ovf_event[HIGH_BASE-1:0]) |=> stat_r[IRQ_BIT_LOW])
      else $error("low word overflow did not set status");

   a_stat_set_high: assert property (@(posedge pclk) disable iff (!presetn)
      (|ovf_event[N_BUF-1:HIGH_BASE]) |=> stat_r[IRQ_BIT_HIGH])
      else $error("high word overflow did not set status");

   a_stat_clears: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && sel_stat && pwdata[IRQ_BIT_LOW] && !(|ovf_event[HIGH_BASE-1:0]))
         |=> !stat_r[IRQ_BIT_LOW])
      else $error("writing one did not clear status");

   a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && sel_mask) |=> mask_r == $past(pwdata[IRQ_W-1:0]))
      else $error("mask write lost");

   a_mask_kept: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr && sel_mask) |=> mask_r == $past(mask_r))
      else $error("mask changed without a write");

   a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
      (mask_r[0] && stat_r[0]) |-> ##[0:1] irq)
      else $error("unmasked status did not raise irq");

   a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      ((stat_r & mask_r) == IRQ_RESET) |-> !irq)
      else $error("irq high with nothing unmasked");

endmodule

`default_nettype wire
